// >>> dv/gpb_pin_model.sv
// Board side of one port: pads driven back onto the input pins
`timescale 1ns/1ps
module gpb_pin_model
(
    input  wire gpb_pkg::gpb_pad_t pad,
    input  wire logic [7:0]        ext,
    output logic [7:0]             pin
);
    import gpb_pkg::*;
    // Driven bits follow the pad, released bits take the external pull level
    assign pin = (pad.out & ~pad.oe_n) | (ext & pad.oe_n);
endmodule : gpb_pin_model

// >>> dv/gpb_ports_assertions.sv
// Port-level checker for the two-port GPIO block
`timescale 1ns/1ps
module gpb_ports_assertions
(
    input wire logic                  sys_clk,
    input wire logic                  srst,
    input wire gpb_pkg::gpb_apb_req_t apb_req,
    input wire logic [31:0]           prdata,
    input wire gpb_pkg::gpb_pad_t     first_port_pad,
    input wire logic [5:0]            first_port_led_drive,
    input wire logic                  first_port_analog_6,
    input wire gpb_pkg::gpb_pad_t     second_port_pad,
    input wire logic                  serial_unit_enable,
    input wire logic                  serial_tx_data,
    input wire logic [1:0][1:0]       first_timer_els,
    input wire logic [1:0]            first_timer_out,
    input wire logic [1:0]            first_timer_oe,
    input wire logic [4:0]            converter_channel_select,
    input wire logic                  second_port_high_nibble_lcd_enable,
    input wire logic [7:0]            lcd_frontplane
);
    import gpb_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Read access phase on the LED register
    wire rd_led = apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_req.paddr == 12'h030;
    property p_rst_b;
        $fell(srst) |-> first_port_pad.oe_n == 8'hFF && first_port_led_drive == 6'h00;
    endproperty
    a_rst_b: assert property (p_rst_b) else $error("port b driving after reset");
    property p_rst_c;
        $fell(srst) |-> second_port_pad.oe_n == 8'hFF;
    endproperty
    a_rst_c: assert property (p_rst_c) else $error("port c driving after reset");
    // LED sink only on a pin that is driving
    property p_led_out;
        (first_port_led_drive & first_port_pad.oe_n[5:0]) == 6'h00;
    endproperty
    a_led_out: assert property (p_led_out) else $error("led on input pin");
    property p_serial;
        serial_unit_enable |=> !first_port_pad.oe_n[0] && first_port_pad.oe_n[1]
            && first_port_pad.out[0] == $past(serial_tx_data);
    endproperty
    a_serial: assert property (p_serial) else $error("serial pins not taken");
    property p_first_timer;
        first_timer_els[0] != ELS_OFF && first_timer_oe[0] |=> !first_port_pad.oe_n[2]
            && first_port_pad.out[2] == $past(first_timer_out[0]);
    endproperty
    a_first_timer: assert property (p_first_timer) else $error("timer pin not taken");
    property p_adc;
        converter_channel_select == ADC_CH4 |=> first_port_analog_6 && first_port_pad.oe_n[6];
    endproperty
    a_adc: assert property (p_adc) else $error("analog pin not taken");
    property p_lcd;
        second_port_high_nibble_lcd_enable |=> second_port_pad.oe_n[7:4] == 4'h0
            && second_port_pad.out[7:4] == $past(lcd_frontplane[7:4]);
    endproperty
    a_lcd: assert property (p_lcd) else $error("frontplane nibble not taken");
    property p_led_rd;
        rd_led |-> prdata[31:6] == 26'h000_0000;
    endproperty
    a_led_rd: assert property (p_led_rd) else $error("led top bits not zero");
    c_serial: cover property (serial_unit_enable);
    c_led_rd: cover property (rd_led);
    c_lcd: cover property (second_port_high_nibble_lcd_enable);
endmodule : gpb_ports_assertions
bind gpb_ports gpb_ports_assertions chk_u (
    .sys_clk(sys_clk), .srst(srst), .apb_req(apb_req), .prdata(prdata),
    .first_port_pad(first_port_pad), .first_port_led_drive(first_port_led_drive),
    .first_port_analog_6(first_port_analog_6), .second_port_pad(second_port_pad),
    .serial_unit_enable(serial_unit_enable), .serial_tx_data(serial_tx_data),
    .first_timer_els(first_timer_els), .first_timer_out(first_timer_out),
    .first_timer_oe(first_timer_oe), .converter_channel_select(converter_channel_select),
    .second_port_high_nibble_lcd_enable(second_port_high_nibble_lcd_enable),
    .lcd_frontplane(lcd_frontplane));

// >>> dv/gpb_ports_tb.sv
// Self-checking bench for the two-port GPIO block
`timescale 1ns/1ps
module gpb_ports_tb;
    import gpb_pkg::*;
    // Row: direction, address, write data, expected read, expected error
    typedef struct packed {logic w; logic [11:0] a; logic [7:0] d, e; logic er;} gpb_row_t;
    // Each latch is loaded before its direction bits go high
    localparam gpb_row_t ROWS [11] = '{
        '{1'b1, 12'h004, 8'hA5, 8'h00, 1'b0}, '{1'b0, 12'h004, 8'h00, 8'h3E, 1'b0},
        '{1'b1, 12'h014, 8'hF0, 8'h00, 1'b0}, '{1'b0, 12'h004, 8'h00, 8'hAE, 1'b0},
        '{1'b0, 12'h014, 8'h00, 8'hF0, 1'b0}, '{1'b1, 12'h030, 8'hFF, 8'h00, 1'b0},
        '{1'b0, 12'h030, 8'h00, 8'h3F, 1'b0}, '{1'b1, 12'h008, 8'h5A, 8'h00, 1'b0},
        '{1'b1, 12'h018, 8'h0F, 8'h00, 1'b0}, '{1'b0, 12'h008, 8'h00, 8'hCA, 1'b0},
        '{1'b0, 12'h00C, 8'h00, 8'h00, 1'b1}};
    logic sys_clk, pready, pslverr, rx, an6, an7, er;
    logic srst = 1'b1, ser_en = 1'b0, tx = 1'b1, lcd_h = 1'b0, lcd_l = 1'b0;
    gpb_apb_req_t req = '0;
    gpb_pad_t pad_b, pad_c;
    logic [31:0] prdata, rd;
    logic [7:0] pin_b, pin_c, fp = 8'h96;
    logic [5:0] led;
    logic [1:0][1:0] els1 = '0, els2 = '0;
    logic [1:0] t1o = '0, t1e = '0, t2o = '0, t2e = '0, t1p, t2p;
    logic [4:0] adc = 5'h00;
    int err_total = 0, comparisons = 0, cyc = 0;
    gpb_ports dut_u (.sys_clk(sys_clk), .srst(srst), .apb_req(req), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .first_port_pin_in(pin_b),
        .first_port_pad(pad_b), .first_port_led_drive(led), .first_port_analog_6(an6),
        .first_port_analog_7(an7), .second_port_pin_in(pin_c), .second_port_pad(pad_c),
        .serial_unit_enable(ser_en), .serial_tx_data(tx), .serial_rx_data(rx),
        .first_timer_els(els1), .first_timer_out(t1o), .first_timer_oe(t1e),
        .first_timer_channel_pin(t1p), .second_timer_els(els2), .second_timer_out(t2o),
        .second_timer_oe(t2e), .second_timer_channel_pin(t2p),
        .converter_channel_select(adc), .second_port_high_nibble_lcd_enable(lcd_h),
        .second_port_low_nibble_lcd_enable(lcd_l), .lcd_frontplane(fp));
    // External pulls: port b 3E, port c C3
    gpb_pin_model pb_u (.pad(pad_b), .ext(8'h3E), .pin(pin_b));
    gpb_pin_model pc_u (.pad(pad_c), .ext(8'hC3), .pin(pin_c));
    initial
    begin
        sys_clk = 0;
        forever #10 sys_clk = ~sys_clk;
    end
    // Hang guard, far above the roughly 90 cycles needed
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            err_total++;
            summarize();
        end
    end
    task chk(input string n, input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    // One transfer, held until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        req <= '{1'b1, 1'b0, w, a, {24'h00_0000, d}};
        @(posedge sys_clk);
        req.penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        req <= '0;
        @(posedge sys_clk);
    endtask : apb
    task summarize();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : summarize
    initial
    begin
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        foreach (ROWS[i])
        begin
            apb(ROWS[i].w, ROWS[i].a, ROWS[i].d);
            chk("pslverr", {31'h0, er}, {31'h0, ROWS[i].er});
            if (!ROWS[i].w)
                chk("prdata", rd, {24'h00_0000, ROWS[i].e});
        end
        repeat (2) @(posedge sys_clk);
        chk("pad b", {16'h0000, pad_b}, {16'h0000, 8'hA0, 8'h0F});
        chk("pad c", {16'h0000, pad_c}, {16'h0000, 8'h0A, 8'hF0});
        chk("led", {26'h000_0000, led}, 32'h0000_0030);
        $display("register table done");
        // Second reset mid-run: directions clear, latches stay
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        apb(1'b0, 12'h014, 8'h00);
        chk("dir b", rd, 32'h0000_0000);
        apb(1'b0, 12'h018, 8'h00);
        chk("dir c", rd, 32'h0000_0000);
        apb(1'b1, 12'h014, 8'hFF);
        apb(1'b1, 12'h018, 8'hFF);
        apb(1'b0, 12'h004, 8'h00);
        chk("latch b", rd, 32'h0000_00A5);
        apb(1'b0, 12'h008, 8'h00);
        chk("latch c", rd, 32'h0000_005A);
        // LED enables were cleared by the reset; set them again
        apb(1'b1, 12'h030, 8'h3F);
        $display("reset retention done");
        // Serial and timer outputs take pins whose latch holds the opposite level
        ser_en <= 1'b1;
        tx <= 1'b0;
        lcd_h <= 1'b1;
        lcd_l <= 1'b1;
        els1[0] <= 2'h1;
        t1e <= 2'b01;
        els2[1] <= 2'h2;
        t2e <= 2'b10;
        adc <= ADC_CH4;
        repeat (8) @(posedge sys_clk);
        chk("pad c out", {24'h00_0000, pad_c.out}, 32'h0000_0096);
        chk("tx pin", {31'h0, pad_b.out[0]}, 32'h0000_0000);
        chk("rx", {31'h0, rx}, 32'h0000_0001);
        chk("timer one", {31'h0, t1p[0]}, 32'h0000_0000);
        chk("timer two", {31'h0, t2p[1]}, 32'h0000_0000);
        chk("analog", {31'h0, an6}, 32'h0000_0001);
        // Only GPIO output pins 4 and 3 keep LED drive; pin 0 by serial
        chk("led", {26'h000_0000, led}, 32'h0000_0019);
        adc <= ADC_CH5;
        repeat (2) @(posedge sys_clk);
        chk("analog 7", {30'h0, an7, an6}, 32'h0000_0002);
        chk("pin 7 off", {31'h0, pad_b.oe_n[7]}, 32'h0000_0001);
        $display("override done");
        summarize();
    end
endmodule : gpb_ports_tb

// >>> verilog/gpb_pkg.sv
// Shared constants and carrier types for the two-port GPIO block
package gpb_pkg;
    // APB address and data widths
    localparam int AW = 12;
    localparam int DW = 32;
    localparam int PW = 8;   // Port width
    // Register indices; byte address is four times the index
    localparam logic [AW-1:0] IDX_B_DATA = 12'h0001;
    localparam logic [AW-1:0] IDX_C_DATA = 12'h0002;
    localparam logic [AW-1:0] IDX_B_DIR  = 12'h0005;
    localparam logic [AW-1:0] IDX_C_DIR  = 12'h0006;
    localparam logic [AW-1:0] IDX_B_LED  = 12'h000C;
    // Word to byte address shift
    localparam int ADDR_SHIFT = 2;
    // Reset values
    localparam logic [PW-1:0] DIR_RST = 8'h00;
    localparam logic [5:0]    LED_RST = 6'h00;
    localparam int LED_W = 6;   // LED bits of the first port
    // Pin positions of the first port
    localparam int PB_TX  = 0;
    localparam int PB_RX  = 1;
    localparam int PB_T1  = 2;  // Timer one channel 0, +1 for ch 1
    localparam int PB_T2  = 4;  // Timer two channel 0, +1 for ch 1
    localparam int PB_AN4 = 6;
    localparam int PB_AN5 = 7;
    // Converter channel codes mapped onto the first port
    localparam logic [4:0] ADC_CH4 = 5'h04;
    localparam logic [4:0] ADC_CH5 = 5'h05;
    // Edge/level select value that means "timer off"
    localparam logic [1:0] ELS_OFF = 2'h0;

    // APB request from the master
    typedef struct packed {
        logic          psel;
        logic          penable;
        logic          pwrite;
        logic [AW-1:0] paddr;
        logic [DW-1:0] pwdata;
    } gpb_apb_req_t;

    // Registered pad drive of one port
    typedef struct packed {
        logic [PW-1:0] out;    // Output level
        logic [PW-1:0] oe_n;   // Low while driving
    } gpb_pad_t;
endpackage : gpb_pkg

// >>> verilog/gpb_ports.sv
// Two 8-bit GPIO ports with LED drive and peripheral pin override
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
module gpb_ports
(
    input  wire logic                    sys_clk,
    input  wire logic                    srst,
    // APB slave
    input  wire gpb_pkg::gpb_apb_req_t   apb_req,
    output logic                         pready,
    output logic                         pslverr,
    output logic [gpb_pkg::DW-1:0]       prdata,
    // First port pads
    input  wire logic [gpb_pkg::PW-1:0]  first_port_pin_in,
    output gpb_pkg::gpb_pad_t            first_port_pad,
    output logic [gpb_pkg::LED_W-1:0]    first_port_led_drive,
    output logic                         first_port_analog_6,
    output logic                         first_port_analog_7,
    // Second port pads
    input  wire logic [gpb_pkg::PW-1:0]  second_port_pin_in,
    output gpb_pkg::gpb_pad_t            second_port_pad,
    // Serial unit
    input  wire logic                    serial_unit_enable,
    input  wire logic                    serial_tx_data,
    output logic                         serial_rx_data,
    // Timers: select per channel, pin drive, capture input
    input  wire logic [1:0][1:0]         first_timer_els,
    input  wire logic [1:0]              first_timer_out,
    input  wire logic [1:0]              first_timer_oe,
    output logic [1:0]                   first_timer_channel_pin,
    input  wire logic [1:0][1:0]         second_timer_els,
    input  wire logic [1:0]              second_timer_out,
    input  wire logic [1:0]              second_timer_oe,
    output logic [1:0]                   second_timer_channel_pin,
    // Converter
    input  wire logic [4:0]              converter_channel_select,
    // Display frontplanes 26..19
    input  wire logic                    second_port_high_nibble_lcd_enable,
    input  wire logic                    second_port_low_nibble_lcd_enable,
    input  wire logic [gpb_pkg::PW-1:0]  lcd_frontplane
);
    import gpb_pkg::*;

    // Register map: one byte per aligned 32-bit word, holding the
    // first port data, second port data, first port direction,
    // second port direction and first port LED enable.
    // Byte addresses are the register indices times four, so a
    // misaligned address never selects a register.
    // Bus timing: read data is captured in the setup cycle and
    // shown in the access cycle, which always completes at once.
    // Pad timing: every pad output is registered, so a register
    // write or an override change reaches the pads one edge later.
    // Pin timing: a level that changes at a pad is readable about
    // four edges later, once the three-stage filter has settled.
    // Peripheral controls come from modules on this clock, so they
    // need no synchroniser; only the two pad buses cross in from
    // outside.

    // Byte address of a register index
    function automatic logic [AW-1:0] byte_addr(
        input logic [AW-1:0] idx
    );
        byte_addr = AW'(idx << ADDR_SHIFT);
    endfunction : byte_addr

    // Per-bit read view: latch when output, pin when input
    // Used by both ports, once each
    function automatic logic [PW-1:0] read_view(
        input logic [PW-1:0] dir,
        input logic [PW-1:0] latch,
        input logic [PW-1:0] pin
    );
        read_view = (dir & latch) | (~dir & pin);
    endfunction : read_view

    // The data latches have no reset on purpose: a warm reset must
    // not disturb what software last wrote. Until the first write
    // they are unknown, but the direction mask keeps that unknown
    // off the pads and out of the read view.
    // Software registers
    logic [PW-1:0]    b_latch_ff;   // No reset
    logic [PW-1:0]    c_latch_ff;   // No reset
    logic [PW-1:0]    b_dir_ff;
    logic [PW-1:0]    c_dir_ff;
    logic [LED_W-1:0] b_led_ff;
    logic [DW-1:0]    rdata_ff;

    // Three stages guard against a metastable first stage; the
    // filtered level only follows once stages two and three agree,
    // which also rejects a one-cycle glitch on the pad.
    // The stages reset to zero, so pins read low until refilled.
    // Pin synchronisers, three stages each
    logic [PW-1:0]    b_s1_ff;
    logic [PW-1:0]    b_s2_ff;
    logic [PW-1:0]    b_s3_ff;
    logic [PW-1:0]    b_pin_ff;     // Filtered level
    logic [PW-1:0]    c_s1_ff;
    logic [PW-1:0]    c_s2_ff;
    logic [PW-1:0]    c_s3_ff;
    logic [PW-1:0]    c_pin_ff;

    // Every pad output leaves through a flop, so pins never glitch
    // Registered pad outputs
    gpb_pad_t         b_pad_ff;
    gpb_pad_t         c_pad_ff;
    logic [LED_W-1:0] led_drv_ff;
    logic             an6_ff;
    logic             an7_ff;

    // Decode works on the full address in both bus phases: the
    // setup cycle uses it for the read capture, the access cycle
    // for the write strobe and the error response.
    // Write data above the low byte is ignored.
    // APB decode
    wire logic          setup   = apb_req.psel & ~apb_req.penable;
    wire logic          access  = apb_req.psel & apb_req.penable;
    wire logic [AW-1:0] addr    = apb_req.paddr;
    wire logic          hit_bd  = addr == byte_addr(IDX_B_DATA);
    wire logic          hit_cd  = addr == byte_addr(IDX_C_DATA);
    wire logic          hit_br  = addr == byte_addr(IDX_B_DIR);
    wire logic          hit_cr  = addr == byte_addr(IDX_C_DIR);
    wire logic          hit_led = addr == byte_addr(IDX_B_LED);
    wire logic          hit_any = hit_bd | hit_cd | hit_br
                                | hit_cr | hit_led;
    wire logic          wr      = access & apb_req.pwrite & hit_any;
    wire logic [PW-1:0] wbyte   = apb_req.pwdata[PW-1:0];

    // Read views of both ports
    wire logic [PW-1:0] b_view = read_view(b_dir_ff, b_latch_ff,
                                           b_pin_ff);
    wire logic [PW-1:0] c_view = read_view(c_dir_ff, c_latch_ff,
                                           c_pin_ff);

    // Unmapped addresses read as zero; the error flag tells the
    // master that nothing was there.
    // Read multiplexer, narrow data in low bits
    logic [PW-1:0] rsel;
    always_comb
    begin
        if (hit_bd)
            rsel = b_view;
        else if (hit_cd)
            rsel = c_view;
        else if (hit_br)
            rsel = b_dir_ff;
        else if (hit_cr)
            rsel = c_dir_ff;
        else if (hit_led)
            rsel = {2'b00, b_led_ff};
        else
            rsel = '0;
    end

    // No register needs more than one cycle, so the slave never
    // stretches an access; flexibility is traded for a simple
    // master side.
    // The error flag marks an access that hit no register.
    // Zero wait states; unmapped access gets an error
    assign pready  = access;
    assign pslverr = access & ~hit_any;
    assign prdata  = rdata_ff;

    // Capturing early keeps prdata on a flop, at the cost of showing
    // a pin level one cycle older than the access edge.
    // Read data captured in the setup cycle
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            rdata_ff <= '0;
        else if (setup)
            rdata_ff <= {{(DW-PW){1'b0}}, rsel};
    end

    // A write in input mode changes only the latch, never the value
    // read back, since the read view takes the pin for input bits.
    // No reset branch here, by design.
    // Data latches: written regardless of direction, reset ignored
    always_ff @(posedge sys_clk)
    begin
        if (wr && hit_bd)
            b_latch_ff <= wbyte;
        if (wr && hit_cd)
            c_latch_ff <= wbyte;
    end

    // Setting a direction bit before loading the latch would drive a
    // stale level for at least two cycles; that ordering is left to software.
    // The two top LED bits are not stored, so they read as zero.
    // Direction and LED registers
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            b_dir_ff <= DIR_RST;
            c_dir_ff <= DIR_RST;
            b_led_ff <= LED_RST;
        end
        else if (wr)
        begin
            if (hit_br)
                b_dir_ff <= wbyte;
            if (hit_cr)
                c_dir_ff <= wbyte;
            if (hit_led)
                b_led_ff <= wbyte[LED_W-1:0];
        end
    end

    // Pin synchronisers; filtered level moves when stages 2 and 3 agree
    wire logic [PW-1:0] b_agree = ~(b_s2_ff ^ b_s3_ff);
    wire logic [PW-1:0] c_agree = ~(c_s2_ff ^ c_s3_ff);
    wire logic [PW-1:0] nxt_b_pin = (b_agree & b_s2_ff)
                                  | (~b_agree & b_pin_ff);
    wire logic [PW-1:0] nxt_c_pin = (c_agree & c_s2_ff)
                                  | (~c_agree & c_pin_ff);

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            b_s1_ff  <= '0;
            b_s2_ff  <= '0;
            b_s3_ff  <= '0;
            b_pin_ff <= '0;
            c_s1_ff  <= '0;
            c_s2_ff  <= '0;
            c_s3_ff  <= '0;
            c_pin_ff <= '0;
        end
        else
        begin
            b_s1_ff  <= first_port_pin_in;
            b_s2_ff  <= b_s1_ff;
            b_s3_ff  <= b_s2_ff;
            b_pin_ff <= nxt_b_pin;
            c_s1_ff  <= second_port_pin_in;
            c_s2_ff  <= c_s1_ff;
            c_s3_ff  <= c_s2_ff;
            c_pin_ff <= nxt_c_pin;
        end
    end

    // An override wins over the port's own direction and data, but
    // the data latch still takes writes, so the pin resumes the last
    // written level when the peripheral lets go.
    // A timer channel is idle while its edge/level select is zero.
    // Peripheral takeover conditions of the first port
    wire logic sci_on = serial_unit_enable;
    wire logic t1_0 = first_timer_els[0] != ELS_OFF;
    wire logic t1_1 = first_timer_els[1] != ELS_OFF;
    wire logic t2_0 = second_timer_els[0] != ELS_OFF;
    wire logic t2_1 = second_timer_els[1] != ELS_OFF;
    wire logic an_6 = converter_channel_select == ADC_CH4;
    wire logic an_7 = converter_channel_select == ADC_CH5;

    // Bits 7..0: analog 7, analog 6, timer two, timer one, serial
    // Taken pins, one bit per pin
    wire logic [PW-1:0] b_taken = {an_7, an_6, t2_1, t2_0,
                                   t1_1, t1_0, sci_on, sci_on};

    // GPIO drive: latch out, direction one enables buffer
    wire logic [PW-1:0] b_gpio_oe = b_dir_ff;
    // Masked so pads show no stale latch while input
    wire logic [PW-1:0] b_gpio_out = b_latch_ff & b_dir_ff;

    // Peripheral drive of the first port
    wire logic [PW-1:0] b_per_out = {
        1'b0, 1'b0,
        second_timer_out[1], second_timer_out[0],
        first_timer_out[1], first_timer_out[0],
        1'b0, serial_tx_data};
    // The serial unit owns the receive pin but never drives it
    // Receive and analog pins never drive
    wire logic [PW-1:0] b_per_oe = {
        1'b0, 1'b0,
        second_timer_oe[1], second_timer_oe[0],
        first_timer_oe[1], first_timer_oe[0],
        1'b0, 1'b1};

    // Per pin, the override mask picks the peripheral drive or the
    // port's own drive; both paths are masked, so no pad is ever
    // driven from two sources at once.
    // Final first port selection
    wire logic [PW-1:0] nxt_b_out = (b_taken & b_per_out)
                                  | (~b_taken & b_gpio_out);
    wire logic [PW-1:0] nxt_b_oe  = (b_taken & b_per_oe)
                                  | (~b_taken & b_gpio_oe);

    // LED bits act only where the port itself drives the pin as an
    // output; the strong sink level differs per pin position and
    // is set by the pad cell, so one enable bit per pin is enough.
    // The transmit pin is the exception: serial drive plus LED bit
    // zero selects the high sink although the port lost the pin.
    // LED drive on output GPIO pins; strong level fixed per pin
    wire logic [LED_W-1:0] b_led_gpio = b_led_ff
                                      & b_dir_ff[LED_W-1:0]
                                      & ~b_taken[LED_W-1:0];
    // Transmit pin gets high sink while serial owns it
    wire logic led_tx = sci_on & b_led_ff[PB_TX];
    wire logic [LED_W-1:0] nxt_led = b_led_gpio
                                   | {{(LED_W-1){1'b0}}, led_tx};

    // A display nibble drives its pins whatever the direction; the
    // frontplane bus has its highest frontplane on pin 7.
    // GPIO output data is masked while a pin is an input.
    // Second port: display nibbles override GPIO
    wire logic [PW-1:0] c_lcd = {
        {(PW/2){second_port_high_nibble_lcd_enable}},
        {(PW/2){second_port_low_nibble_lcd_enable}}};
    wire logic [PW-1:0] nxt_c_out = (c_lcd & lcd_frontplane)
                                  | (~c_lcd & c_latch_ff & c_dir_ff);
    wire logic [PW-1:0] nxt_c_oe  = c_lcd | c_dir_ff;

    // After reset all buffers are off and every pin is an input, so
    // nothing drives the board until software asks for it.
    // The analog flags share this block to keep their timing.
    // Pad registers, disabled buffers after reset
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            b_pad_ff.out  <= '0;
            b_pad_ff.oe_n <= '1;
            c_pad_ff.out  <= '0;
            c_pad_ff.oe_n <= '1;
            led_drv_ff    <= '0;
            an6_ff        <= 1'b0;
            an7_ff        <= 1'b0;
        end
        else
        begin
            b_pad_ff.out  <= nxt_b_out;
            b_pad_ff.oe_n <= ~nxt_b_oe;
            c_pad_ff.out  <= nxt_c_out;
            c_pad_ff.oe_n <= ~nxt_c_oe;
            led_drv_ff    <= nxt_led;
            an6_ff        <= an_6;
            an7_ff        <= an_7;
        end
    end

    // Pad structs pass straight through; they are flops already
    // Outputs
    assign first_port_pad       = b_pad_ff;
    assign second_port_pad      = c_pad_ff;
    assign first_port_led_drive = led_drv_ff;
    assign first_port_analog_6  = an6_ff;
    assign first_port_analog_7  = an7_ff;

    // Peripherals see the filtered level, so their inputs carry the
    // filter delay of a software read of the pin, without its capture cycle.
    // Peripheral inputs from the filtered pin levels
    assign serial_rx_data = b_pin_ff[PB_RX];
    assign first_timer_channel_pin =
        b_pin_ff[PB_T1+1:PB_T1];
    assign second_timer_channel_pin =
        b_pin_ff[PB_T2+1:PB_T2];

endmodule : gpb_ports
